// File: rss_defs.svh
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH
// Clock rate and code clock
`define RSS_CLK_MHZ     200
`define RSS_CLK_KHZ     200000
`define RSS_CCLK_KHZ    1800
`define RSS_CCLK_CYC    (`RSS_CLK_KHZ / `RSS_CCLK_KHZ)
// Guard mask delay after a code transition
`define RSS_MASK_US     15
`define RSS_MASK_CYC    (`RSS_MASK_US * `RSS_CLK_MHZ)
// Soft-start delays
`define RSS_TD1_US      1500
`define RSS_TD3_US      200
// Reference scale and levels
`define RSS_LSB_UV      6250
`define RSS_BOOT_MV     1081
`define RSS_UVEN_MV     600
`define RSS_BOOT_LVL    ((`RSS_BOOT_MV * 1000) / `RSS_LSB_UV)
`define RSS_UVEN_LVL    ((`RSS_UVEN_MV * 1000) / `RSS_LSB_UV)
// Time to boot level is this figure (us*kHz) over the ceiling in kHz
`define RSS_TD2_K       527500
`define RSS_OCP_PCT_HI  8'h96
`define RSS_OCP_PCT_LO  8'h64
// Register offsets and reset values
`define RSS_ADDR_RATE   8'h00
`define RSS_ADDR_STAT   8'h04
`define RSS_ADDR_CODE   8'h08
`define RSS_RATE_RST    16'h01F4
`endif

// File: rss_pkg.sv
package rss_pkg;
  // Main sequence states
  typedef enum logic [2:0] {
    ST_OFF, ST_DELAY, ST_RAMP_BOOT, ST_HOLD, ST_RAMP_TGT, ST_RUN
  } rss_state_t;
  // Code change tracker states
  typedef enum logic [1:0] {DV_IDLE, DV_CONFIRM, DV_ARM, DV_STEP} rss_dv_t;
  // Protection enables handed to the analog side
  typedef struct packed {
    logic ov_en;
    logic uv_en;
    logic ocp_boost;
  } rss_guard_t;
endpackage

// File: rss_proc_model.sv
`timescale 1ns/1ps
// ****************************
// Processor: code lines, enable
// ****************************
module rss_proc_model (
  // Clock
  input  wire logic       i_clk,
  // Lines to the device
  output logic      [7:0] o_voltage_code,
  output logic            o_regulator_enable_in
);
  // Parked low: device held disabled until asked
  initial begin
    o_voltage_code        = 8'h00;
    o_regulator_enable_in = 1'b0;
  end
  // Jumps of several steps are left to the device to pace
  task set_code(input logic [7:0] c);
    @(posedge i_clk);
    o_voltage_code <= c;
  endtask
  // Low level doubles as device reset
  task set_enable(input logic b);
    @(posedge i_clk);
    o_regulator_enable_in <= b;
  endtask
endmodule // rss_proc_model

// File: rss_seq_properties.sv
`timescale 1ns/1ps
// ****************************
// Sequencer port checker
// ****************************
module rss_seq_properties
  import rss_pkg::*;
#(
  parameter int unsigned CW = 8
) (
  input wire logic          i_clk,
  input wire logic          i_rst_n,
  input wire logic          i_regulator_enable_in,
  input wire logic          i_supply_ok,
  input wire logic          i_out_below_ref,
  input wire logic [CW-1:0] o_ref_code,
  input wire rss_guard_t    o_guard,
  input wire logic [7:0]    o_ocp_limit_pct,
  input wire logic          o_high_side_switch,
  input wire logic          o_low_side_switch,
  input wire logic          o_fault,
  input wire logic          o_softstart_done_flag,
  input wire logic          o_rate_is_boost
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Edges with enable and supply live, saturating; clears drop the reference
  logic [1:0] live_cnt;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      live_cnt <= 2'd0;
    end else if (!(i_regulator_enable_in && i_supply_ok)) begin
      live_cnt <= 2'd0;
    end else if (live_cnt != 2'd3) begin
      live_cnt <= live_cnt + 2'd1;
    end
  end
  a_done_cleared: assert property (!i_regulator_enable_in |=> !o_softstart_done_flag)
    else $error("done flag high while disabled");
  a_off_disabled: assert property (!i_regulator_enable_in |=> !o_high_side_switch && !o_low_side_switch)
    else $error("switch on while disabled");
  a_off_no_supply: assert property (!i_supply_ok |=> !o_high_side_switch && !o_low_side_switch)
    else $error("switch on without supply");
  a_ocp_raised: assert property ($rose(o_guard.ocp_boost) |-> ##[0:1] o_ocp_limit_pct == 8'h96)
    else $error("limit not raised in transition");
  a_guard_masked: assert property ($rose(o_guard.ocp_boost) |-> ##[0:1] (!o_guard.ov_en && !o_guard.uv_en))
    else $error("guards not masked in transition");
  a_ref_one_lsb: assert property ($changed(o_ref_code) && live_cnt == 2'd3 |->
    (o_ref_code == $past(o_ref_code) + 1) || (o_ref_code + 1 == $past(o_ref_code)))
    else $error("reference moved by more than one step");
  a_uv_at_level: assert property ($rose(o_guard.uv_en) && !o_softstart_done_flag |-> o_ref_code inside {[95:97]})
    else $error("undervoltage enabled off level");
  a_ov_in_ramp: assert property (!o_softstart_done_flag && o_guard.uv_en |-> o_guard.ov_en)
    else $error("overvoltage off during soft-start");
  a_uv_latches: assert property ((live_cnt == 2'd3 && o_guard.uv_en && i_out_below_ref) [*3] |-> ##[1:3] o_fault)
    else $error("undervoltage fault not latched");
  a_hs_off_fault: assert property (o_fault ##1 o_fault |-> !o_high_side_switch)
    else $error("high switch on in fault");
  a_boost_w_done: assert property (o_softstart_done_flag |-> o_rate_is_boost)
    else $error("rate pin not in boost meaning");
endmodule // rss_seq_properties

// File: rss_sequencer.sv
`timescale 1ns/1ps
`include "rss_defs.svh"

module rss_sequencer
  import rss_pkg::*;
#(
  parameter int unsigned TD1_CYC = `RSS_TD1_US * `RSS_CLK_MHZ,
  parameter int unsigned TD3_CYC = `RSS_TD3_US * `RSS_CLK_MHZ,
  parameter int unsigned CW      = 8
) (
  // Clock, reset, enable
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_ce,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Processor side
  input  wire logic [CW-1:0] i_voltage_code,
  input  wire logic          i_regulator_enable_in,
  // Supply and analog status
  input  wire logic          i_supply_ok,
  input  wire logic          i_out_below_ref,
  input  wire logic          i_over_voltage,
  // Control loop commands
  input  wire logic          i_loop_hs,
  input  wire logic          i_loop_ls,
  // Converter controls
  output logic [CW-1:0]      o_ref_code,
  output rss_guard_t         o_guard,
  output logic [7:0]         o_ocp_limit_pct,
  output logic               o_high_side_switch,
  output logic               o_low_side_switch,
  output logic               o_fault,
  output logic               o_softstart_done_flag,
  output logic               o_rate_is_boost,
  output logic [15:0]        o_boost_freq_ceiling
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  localparam int unsigned DW = 20;
  if (TD1_CYC < 1 || TD1_CYC >= (1 << DW) || TD3_CYC < 1 ||
      TD3_CYC >= (1 << DW) || CW != 8) begin : g_bad_param
    $error("rss_sequencer: unsupported parameter value");
  end

  localparam logic [CW-1:0] BOOT_LVL = CW'(`RSS_BOOT_LVL);
  localparam logic [CW-1:0] UVEN_LVL = CW'(`RSS_UVEN_LVL);
  localparam logic [6:0]    CC_LAST  = 7'(`RSS_CCLK_CYC - 1);
  localparam logic [6:0]    CC_HALF  = 7'(`RSS_CCLK_CYC / 2);
  localparam logic [11:0]   MASK_CYC = 12'(`RSS_MASK_CYC);

  // ***************************************************************
  // State
  // ***************************************************************
  rss_state_t        state;        // Main sequence
  rss_dv_t           dv;           // Code change tracker
  logic [CW-1:0]     ref_lvl;      // Reference in LSB steps
  logic [CW-1:0]     target;       // Level being approached
  logic [CW-1:0]     cand;         // Code seen on a rising edge
  logic [CW-1:0]     next_ref;     // One step toward target
  logic [DW-1:0]     dly_cnt;      // Delay and hold timer
  logic [6:0]        cc_cnt;       // Code clock divider
  logic              cc_rise;      // Code clock rising edge
  logic              cc_fall;      // Code clock falling edge
  logic [11:0]       mask_cnt;     // Guard re-enable delay
  logic              dv_active;    // Transition in progress
  logic              dv_step;      // Step taken this cycle
  logic [15:0]       rate_khz;     // Rate pin setting
  logic [DW-1:0]     ss_period;    // Soft-start step period
  logic [DW-1:0]     ss_cnt;       // Soft-start oscillator
  logic              ss_tick;      // Soft-start step strobe
  logic              ramping;      // In either soft-start ramp
  logic              softstart;    // Anywhere in soft-start
  logic              live;         // Supplies good and enabled
  logic              fault_uv;     // Latched undervoltage
  logic              fault_ov;     // Latched overvoltage
  logic              uv_seen;      // Undervoltage last cycle
  logic              ls_armed;     // High side has switched
  logic              switching;    // Drivers may follow loop

  assign live      = i_supply_ok && i_regulator_enable_in;
  assign ramping   = (state == ST_RAMP_BOOT) || (state == ST_RAMP_TGT);
  assign softstart = ramping || (state == ST_HOLD);
  assign switching = (softstart || state == ST_RUN) && !fault_uv && !fault_ov;
  assign dv_active = (dv == DV_ARM) || (dv == DV_STEP);
  assign cc_rise   = (cc_cnt == 7'h00);
  assign cc_fall   = (cc_cnt == CC_HALF);
  assign dv_step   = dv_active && cc_rise && (ref_lvl != target);
  assign ss_tick   = ramping && (ss_cnt >= ss_period - 1'b1);

  // One LSB toward the target, never past it
  always_comb begin
    if (ref_lvl < target) begin
      next_ref = ref_lvl + 1'b1;
    end else if (ref_lvl > target) begin
      next_ref = ref_lvl - 1'b1;
    end else begin
      next_ref = ref_lvl;
    end
  end

  // ***************************************************************
  // Code clock, free running
  // ***************************************************************
  // Rise at count zero, fall at mid period
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cc_cnt <= 7'h00;
    end else if (i_ce) begin
      if (cc_cnt == CC_LAST) begin
        cc_cnt <= 7'h00;
      end else begin
        cc_cnt <= cc_cnt + 7'h01;
      end
    end
  end

  // ***************************************************************
  // Soft-start oscillator
  // ***************************************************************
  // Period per step so that the boot level lands on time.
  // The divide is registered to keep it off the step path.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ss_period <= 20'h0_0001;
    end else if (i_ce) begin
      if (rate_khz == 16'h0000) begin
        ss_period <= 20'h0_0001;  // Guard against divide by zero
      end else begin
        ss_period <= DW'((64'(`RSS_TD2_K) * `RSS_CLK_MHZ) /
                         (64'(rate_khz) * `RSS_BOOT_LVL)) + 20'h0_0001;
      end
    end
  end

  // Runs only while ramping; each wrap is one reference step
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ss_cnt <= 20'h0_0000;
    end else if (i_ce) begin
      if (!ramping || ss_tick) begin
        ss_cnt <= 20'h0_0000;
      end else begin
        ss_cnt <= ss_cnt + 20'h0_0001;
      end
    end
  end

  // ***************************************************************
  // Main sequence and reference
  // ***************************************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state   <= ST_OFF;
      ref_lvl <= '0;
      target  <= '0;
      dly_cnt <= '0;
    end else if (i_ce) begin
      if (!live) begin
        // Enable low or supply short: start over from zero
        state   <= ST_OFF;
        ref_lvl <= '0;
        target  <= '0;
        dly_cnt <= '0;
      end else begin
        case (state)
          ST_OFF: begin
            state   <= ST_DELAY;
            dly_cnt <= '0;
          end
          ST_DELAY: begin
            if (dly_cnt == DW'(TD1_CYC - 1)) begin
              state   <= ST_RAMP_BOOT;
              dly_cnt <= '0;
              target  <= BOOT_LVL;
            end else begin
              dly_cnt <= dly_cnt + 1'b1;
            end
          end
          ST_RAMP_BOOT: begin
            if (ref_lvl == BOOT_LVL) begin
              state <= ST_HOLD;
            end else if (ss_tick) begin
              ref_lvl <= next_ref;
              if (next_ref == BOOT_LVL) begin
                state <= ST_HOLD;
              end
            end
          end
          ST_HOLD: begin
            // Code lines read at the end of the hold
            if (dly_cnt == DW'(TD3_CYC - 1)) begin
              state   <= ST_RAMP_TGT;
              target  <= i_voltage_code;
              dly_cnt <= '0;
            end else begin
              dly_cnt <= dly_cnt + 1'b1;
            end
          end
          ST_RAMP_TGT: begin
            if (ref_lvl == target) begin
              state <= ST_RUN;
            end else if (ss_tick) begin
              ref_lvl <= next_ref;
              if (next_ref == target) begin
                state <= ST_RUN;
              end
            end
          end
          ST_RUN: begin
            // Confirmed code becomes the new target
            if (dv == DV_CONFIRM && cc_fall && i_voltage_code == cand) begin
              target <= cand;
            end
            if (dv_step) begin
              ref_lvl <= next_ref;
            end
          end
          default: begin
            state <= ST_OFF;
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // Code change tracker
  // ***************************************************************
  // Changes are only looked at in IDLE, so a code moving
  // mid-transition is ignored until the next rising edge after.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dv   <= DV_IDLE;
      cand <= '0;
    end else if (i_ce) begin
      if (!live || state != ST_RUN) begin
        dv <= DV_IDLE;
      end else begin
        case (dv)
          DV_IDLE: begin
            if (cc_rise && i_voltage_code != target) begin
              cand <= i_voltage_code;
              dv   <= DV_CONFIRM;
            end
          end
          DV_CONFIRM: begin
            if (cc_fall) begin
              // Unconfirmed codes are dropped
              dv <= (i_voltage_code == cand) ? DV_ARM : DV_IDLE;
            end
          end
          DV_ARM, DV_STEP: begin
            if (cc_rise) begin
              // Done in the cycle the last step lands
              dv <= (next_ref == target) ? DV_IDLE : DV_STEP;
            end
          end
          default: begin
            dv <= DV_IDLE;
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // Guard masking after transitions
  // ***************************************************************
  // Reloads while a transition runs, drains once it ends
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_cnt <= 12'h000;
    end else if (i_ce) begin
      if (!live) begin
        mask_cnt <= 12'h000;
      end else if (dv_active) begin
        mask_cnt <= MASK_CYC;
      end else if (mask_cnt != 12'h000) begin
        mask_cnt <= mask_cnt - 12'h001;
      end
    end
  end

  // Guard enables and overcurrent scaling
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_guard         <= '0;
      o_ocp_limit_pct <= `RSS_OCP_PCT_LO;
    end else if (i_ce) begin
      if (softstart) begin
        o_guard.ov_en     <= 1'b1;
        o_guard.uv_en     <= (ref_lvl >= UVEN_LVL);
        o_guard.ocp_boost <= 1'b0;
        o_ocp_limit_pct   <= `RSS_OCP_PCT_LO;
      end else if (state == ST_RUN && live) begin
        o_guard.ov_en     <= !dv_active && mask_cnt == 12'h000;
        o_guard.uv_en     <= !dv_active && mask_cnt == 12'h000;
        o_guard.ocp_boost <= dv_active || mask_cnt != 12'h000;
        o_ocp_limit_pct   <= (dv_active || mask_cnt != 12'h000) ?
                             `RSS_OCP_PCT_HI : `RSS_OCP_PCT_LO;
      end else begin
        o_guard         <= '0;
        o_ocp_limit_pct <= `RSS_OCP_PCT_LO;
      end
    end
  end

  // ***************************************************************
  // Fault latches
  // ***************************************************************
  // Undervoltage must persist past one cycle; cleared only by
  // dropping enable or supply.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      uv_seen  <= 1'b0;
      fault_uv <= 1'b0;
      fault_ov <= 1'b0;
    end else if (i_ce) begin
      if (!live) begin
        uv_seen  <= 1'b0;
        fault_uv <= 1'b0;
        fault_ov <= 1'b0;
      end else begin
        uv_seen <= o_guard.uv_en && i_out_below_ref;
        if (uv_seen && o_guard.uv_en && i_out_below_ref) begin
          fault_uv <= 1'b1;
        end
        if (o_guard.ov_en && i_over_voltage) begin
          fault_ov <= 1'b1;
        end
      end
    end
  end

  // ***************************************************************
  // Gate drivers
  // ***************************************************************
  // Low side stays off until the high side has switched once, save
  // under an overvoltage fault, so a pre-biased output is not pulled down.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ls_armed <= 1'b0;
    end else if (i_ce) begin
      if (!switching) begin
        ls_armed <= (state == ST_RUN) && ls_armed;
      end else if (i_loop_hs) begin
        ls_armed <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_high_side_switch <= 1'b0;
      o_low_side_switch  <= 1'b0;
      o_fault            <= 1'b0;
    end else if (i_ce) begin
      o_fault <= fault_uv || fault_ov;
      if (!i_supply_ok || !i_regulator_enable_in) begin
        o_high_side_switch <= 1'b0;
        o_low_side_switch  <= 1'b0;
      end else if (fault_ov) begin
        // Protection overrides the low side mask
        o_high_side_switch <= 1'b0;
        o_low_side_switch  <= 1'b1;
      end else begin
        o_high_side_switch <= switching && i_loop_hs;
        o_low_side_switch  <= switching && ls_armed && i_loop_ls;
      end
    end
  end

  // ***************************************************************
  // Status outputs
  // ***************************************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ref_code            <= '0;
      o_softstart_done_flag <= 1'b0;
      o_rate_is_boost       <= 1'b0;
      o_boost_freq_ceiling  <= 16'h0000;
    end else if (i_ce) begin
      o_ref_code            <= ref_lvl;
      o_softstart_done_flag <= live && state == ST_RUN;
      o_rate_is_boost       <= live && state == ST_RUN;
      o_boost_freq_ceiling  <= (live && state == ST_RUN) ? rate_khz : 16'h0000;
    end
  end

  // ***************************************************************
  // APB slave
  // ***************************************************************
  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      rate_khz <= `RSS_RATE_RST;
    end else if (i_ce) begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        case (paddr)
          `RSS_ADDR_RATE: prdata <= {16'h0000, rate_khz};
          `RSS_ADDR_STAT: prdata <= {16'h0000, 1'b0, state, dv_active,
                                     fault_ov, fault_uv,
                                     o_softstart_done_flag, ref_lvl};
          `RSS_ADDR_CODE: prdata <= {16'h0000, cand, target};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;  // Unmapped address
          end
        endcase
      end
      if (psel && penable && pready && pwrite && paddr == `RSS_ADDR_RATE) begin
        rate_khz <= pwdata[15:0];
      end
    end
  end

endmodule // rss_sequencer

// File: tb.sv
`timescale 1ns/1ps
module tb;
  import rss_pkg::*;
  // ****************************
  // Short counts, expectations
  // ****************************
  localparam int TD1  = 20;
  localparam int TD3  = 40;
  localparam int RATE = 65535;
  localparam int BOOT = 1081000 / 6250;              // Boot level in steps
  localparam int TD2  = 527500 * 200 / RATE;         // Cycles to boot level
  localparam int MASK = 15 * 200;                    // Mask tail in cycles
  localparam int CCP  = 200000 / 1800;               // Code clock period
  logic        i_clk, i_rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, code, ref_code, overcurrent_limit;
  logic [31:0] pwdata, prdata, q;
  logic        en, sup, below, ovr, lhs, lls, hs, ls, flt, done, boost, e, ce;
  logic [15:0] ceil;
  rss_guard_t  guard;
  int          fail_count, compares, n, lo, hi;
  rss_sequencer #(.TD1_CYC(TD1), .TD3_CYC(TD3)) rss_sequencer_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_voltage_code(code), .i_regulator_enable_in(en),
    .i_supply_ok(sup), .i_out_below_ref(below), .i_over_voltage(ovr), .i_loop_hs(lhs),
    .i_loop_ls(lls), .o_ref_code(ref_code), .o_guard(guard), .o_ocp_limit_pct(overcurrent_limit),
    .o_high_side_switch(hs), .o_low_side_switch(ls), .o_fault(flt),
    .o_softstart_done_flag(done), .o_rate_is_boost(boost), .o_boost_freq_ceiling(ceil));
  rss_proc_model rss_proc_model_inst (.i_clk(i_clk), .o_voltage_code(code),
    .o_regulator_enable_in(en));
  // Free-running 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // ****************************
  // Compare, bus and wait tasks
  // ****************************
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_pin(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Setup, then access held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // Answer taken at the very edge pready is seen high; watchdog ends a hang
    do @(posedge i_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wait_ref(input logic [7:0] lvl);
    n = 0;
    while (ref_code !== lvl) begin @(negedge i_clk); n++; end
  endtask
  // Polls the state field; hold is long enough to be caught
  task wait_state(input logic [2:0] s);
    n = 0;
    do begin apb(1'b0, 8'h04, 32'h0); n++; end while (q[14:12] !== s);
  endtask
  task final_report();
    $display("counts fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard well beyond the expected run
  initial begin
    repeat (60000) @(posedge i_clk);
    fail_count++;
    final_report();
  end
  // ****************************
  // Main sequence
  // ****************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {i_rst_n, below, ovr, lhs, lls} = '0;
    {sup, ce} = 2'b11;
    fail_count = 0;
    compares = 0;
    void'($urandom(32'heceed54e));
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0); chk_reg(q, 32'h0000_01F4);
    apb(1'b1, 8'h00, RATE); apb(1'b0, 8'h00, 32'h0); chk_reg(q, RATE);
    apb(1'b0, 8'h0C, 32'h0); chk_reg({q[30:0], e}, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'hFFFF_FFFF); apb(1'b0, 8'h04, 32'h0); chk_reg(q[14:12], 0);
    $display("test registers done");
    // Boot ramp, hold, then down to a low code; low loop command masked
    lo = 100 + $urandom % 72;
    rss_proc_model_inst.set_code(8'(BOOT + 5));
    lls <= 1'b1;
    rss_proc_model_inst.set_enable(1'b1);
    wait_state(3'd2); wait_ref(8'(BOOT)); chk_reg(n >= TD2 - 8 && n <= TD2 + BOOT, 1);
    wait_state(3'd3); chk_pin(ref_code, BOOT);
    chk_pin({done, ls, 5'h0, guard}, 16'h0006);
    rss_proc_model_inst.set_code(8'(lo));
    wait_ref(8'(lo)); chk_reg(n * BOOT >= (BOOT - lo) * TD2, 1);
    chk_reg(n <= (BOOT - lo) * (TD2 + BOOT) / BOOT + TD3 + 8, 1);
    repeat (3) @(negedge i_clk);
    chk_pin({done, boost}, 16'h0003); chk_pin(ceil, RATE);
    rss_proc_model_inst.set_enable(1'b0);
    repeat (3) @(negedge i_clk); chk_pin({done, hs, ls}, 0);
    $display("test soft-start low done");
    // Up from boot, then code changes while running
    hi = BOOT + 1 + $urandom % 60;
    rss_proc_model_inst.set_code(8'(hi));
    rss_proc_model_inst.set_enable(1'b1);
    wait_state(3'd3); chk_pin(ls, 0);
    lhs <= 1'b1;
    wait_ref(8'(hi)); chk_reg(n * BOOT >= (hi - BOOT) * TD2, 1);
    chk_reg(n <= (hi - BOOT) * (TD2 + BOOT) / BOOT + TD3 + 8, 1);
    repeat (3) @(negedge i_clk); chk_pin(ls, 1);
    rss_proc_model_inst.set_code(8'(hi + 3));
    wait_ref(8'(hi + 1)); chk_reg(n <= 3 * CCP, 1);
    rss_proc_model_inst.set_code(8'(hi - 2));
    chk_pin({overcurrent_limit, 5'h0, guard}, 16'h9601);
    wait_ref(8'(hi + 3)); chk_reg(n >= 2 * CCP - 1 && n <= 2 * CCP + 1, 1);
    wait_ref(8'(hi - 2)); chk_reg(n <= 8 * CCP, 1);
    repeat (MASK - 100) @(negedge i_clk); chk_pin({overcurrent_limit, 5'h0, guard}, 16'h9601);
    // Clock enable low freezes the mask tail, so expiry slips by the frozen span
    @(posedge i_clk);
    ce <= 1'b0;
    repeat (150) @(negedge i_clk); chk_pin({overcurrent_limit, 5'h0, guard}, 16'h9601);
    @(posedge i_clk);
    ce <= 1'b1;
    repeat (200) @(negedge i_clk); chk_pin({overcurrent_limit, 5'h0, guard}, 16'h6406);
    @(posedge i_clk);
    below <= 1'b1;
    repeat (4) @(negedge i_clk); chk_pin({flt, hs, ls}, 16'h0004);
    @(posedge i_clk);
    below <= 1'b0;
    lhs <= 1'b0;
    rss_proc_model_inst.set_enable(1'b0);
    repeat (3) @(negedge i_clk); chk_pin(flt, 0);
    $display("test code change done");
    // Overvoltage in ramp forces low switch past the mask
    rss_proc_model_inst.set_enable(1'b1);
    wait_state(3'd2);
    ovr <= 1'b1;
    repeat (4) @(negedge i_clk); chk_pin({flt, hs, ls}, 16'h0005);
    @(posedge i_clk);
    ovr <= 1'b0;
    sup <= 1'b0;
    repeat (3) @(negedge i_clk); chk_pin({flt, hs, ls}, 0);
    apb(1'b0, 8'h04, 32'h0); chk_reg(q[14:12], 0);
    $display("test protections done");
    final_report();
  end
endmodule // tb
bind rss_sequencer rss_seq_properties #(.CW(CW)) rss_seq_properties_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_regulator_enable_in(i_regulator_enable_in),
  .i_supply_ok(i_supply_ok), .i_out_below_ref(i_out_below_ref), .o_ref_code(o_ref_code),
  .o_guard(o_guard), .o_ocp_limit_pct(o_ocp_limit_pct),
  .o_high_side_switch(o_high_side_switch), .o_low_side_switch(o_low_side_switch),
  .o_fault(o_fault), .o_softstart_done_flag(o_softstart_done_flag),
  .o_rate_is_boost(o_rate_is_boost));
